/* rtl/scif_len_counter.sv */
// Receive-length counter that pulses on reaching its loaded maximum
`default_nettype none
module scif_len_counter
  import scif_pkg::*;
#(
  parameter int W = LEN_W
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  scif_len_if.cnt   len
);
  logic [W-1:0] max_q, max_d;   // Loaded maximum
  logic [W-1:0] cnt_q, cnt_d;   // Current count
  logic         term_q, term_d; // Terminal pulse

  // Next count, load restarts from zero
  always_comb begin
    max_d  = max_q;
    cnt_d  = cnt_q;
    term_d = 1'b0;
    if (len.load) begin
      max_d = len.max_val;
      cnt_d = '0;
    end else if (len.step && cnt_q != max_q) begin
      cnt_d  = cnt_q + 1'b1;
      term_d = (cnt_q + 1'b1) == max_q; // Reached maximum
    end
  end

  // Register stage
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      max_q  <= '0;
      cnt_q  <= '0;
      term_q <= 1'b0;
    end else begin
      max_q  <= max_d;
      cnt_q  <= cnt_d;
      term_q <= term_d;
    end
  end

  assign len.terminal = term_q;
endmodule : scif_len_counter
`default_nettype wire

/* rtl/scif_len_if.sv */
// Interface: receive-length counter control and terminal status
`default_nettype none
interface scif_len_if #(
  parameter int W = 8
);
  logic         load;      // Load new maximum
  logic [W-1:0] max_val;   // Maximum to load
  logic         step;      // One counter advance
  logic         terminal;  // Counter reached maximum, one cycle
  modport ctrl (output load, output max_val, output step, input terminal);
  modport cnt  (input load, input max_val, input step, output terminal);
endinterface : scif_len_if
`default_nettype wire

/* rtl/scif_pkg.sv */
// Package: offsets, field positions and reset values of the card flag block
`default_nettype none
package scif_pkg;
  // Register offsets on the plain register port
  localparam logic [15:0] CARD_IRQ_FLAGS_ADDR  = 16'hfe01; // Flag register
  localparam logic [15:0] CARD_IRQ_ENABLE_ADDR = 16'hfe02; // Enable register
  localparam logic [15:0] CARD_MODE_ADDR       = 16'hfe0e; // Mode register
  // Flag and enable bit positions
  localparam int WAIT_TIMEOUT_BIT = 7; // Wait timeout or length terminal
  localparam int CARD_CHANGE_BIT  = 6; // Card event
  localparam int SUPPLY_TIMER_BIT = 5; // Supply timer timeout
  localparam int RX_PENDING_BIT   = 4; // Receive data available
  localparam int TX_STATE_BIT     = 3; // Transmit fifo state event
  localparam int TX_DONE_BIT      = 2; // Byte sent
  localparam int TX_FAULT_BIT     = 1; // Transmit error
  localparam int RX_FAULT_BIT     = 0; // Receive error
  // Mode register fields
  localparam int MODE_SYNC_BIT    = 0; // Synchronous card mode
  localparam int MODE_CLKSTOP_BIT = 1; // Synchronous clock-stop mode
  localparam int MODE_BYPASS_BIT  = 2; // UART bypass mode
  localparam int MODE_BREAK_BIT   = 3; // Break detection enable
  localparam int MODE_BLOCK_BIT   = 4; // Block protocol selected
  // Reset values
  localparam logic [7:0] CARD_IRQ_ENABLE_RST = 8'h00; // Enable reset
  localparam logic [7:0] CARD_IRQ_FLAGS_RST  = 8'h00; // Flag reset
  localparam logic [7:0] CARD_MODE_RST       = 8'h00; // Mode reset
  // Flags cleared by a flag register read
  localparam logic [7:0] READ_CLEAR_MASK = 8'he4;
  // Flags cleared by a transmit control read
  localparam logic [7:0] TX_CLEAR_MASK   = 8'h0a;
  // Flags cleared by a receive control read
  localparam logic [7:0] RX_CLEAR_MASK   = 8'h01;
  // Receive-length counter width
  localparam int LEN_W = 8;
endpackage : scif_pkg
`default_nettype wire

/* rtl/scif_sync2.sv */
// Two-flop synchroniser for a bundle of pin levels
`default_nettype none
module scif_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q; // First stage, read only by second
  logic [W-1:0] sync_q; // Second stage

  // Two flops in series
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : scif_sync2
`default_nettype wire

/* rtl/scif_top.sv */
// Card interrupt flags, enables and the single interrupt output
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
module scif_top
  import scif_pkg::*;
(
  input  wire logic        i_core_clk,      // Processor clock
  input  wire logic        i_sys_rst,       // Synchronous reset
  // Register port
  input  wire logic [15:0] i_reg_addr,      // Register address
  input  wire logic [7:0]  i_reg_wdata,     // Write data
  input  wire logic        i_reg_wr,        // Write strobe
  input  wire logic        i_reg_rd,        // Read strobe
  output logic      [7:0]  o_reg_rdata,     // Read data, next cycle
  // Read strobes of neighbouring control registers
  input  wire logic        i_tx_ctl_rd,     // Transmit control read
  input  wire logic        i_rx_ctl_rd,     // Receive control read
  // Interface selection, from the select register
  input  wire logic [1:0]  i_if_select,     // 00 none, 01 ext, 1x int
  // Event pulses and status levels from the selected interface
  input  wire logic        i_int_wait_timeout, // Internal wait timeout
  input  wire logic        i_ext_wait_timeout, // External wait timeout
  input  wire logic        i_supply_timeout,   // Supply timer expired
  input  wire logic        i_rx_fifo_empty,    // Receive fifo empty
  input  wire logic        i_tx_fifo_empty,    // Tx fifo empty status
  input  wire logic        i_tx_fifo_full,     // Tx fifo full status
  input  wire logic        i_byte_sent,        // Data byte sent
  input  wire logic        i_check_sent,       // CRC/LRC byte sent
  input  wire logic        i_break_at_end,     // Break seen at byte end
  input  wire logic        i_break_detected,   // Break status bit
  input  wire logic        i_tx_underrun,      // Underrun status bit
  input  wire logic        i_rx_overrun,       // Overrun event
  input  wire logic        i_rx_parity_err,    // Parity error event
  input  wire logic        i_len_step,         // Falling card clock/etu
  input  wire logic        i_card_fault,       // Interface fault level
  // Pins from outside the clock domain
  input  wire logic        i_card_detect_pin,  // Card present level
  input  wire logic        i_card_io_pin,      // Card io line
  output logic             o_card_irq          // Interrupt to core
);
  scif_len_if #(.W(LEN_W)) len_bus (); // Length counter link

  logic [7:0] enable_q, enable_d; // Enable register
  logic [7:0] flags_q,  flags_d;  // Flag register
  logic [7:0] mode_q,   mode_d;   // Mode register
  logic [7:0] rdata_q,  rdata_d;  // Read data
  logic       irq_q,    irq_d;    // Interrupt output
  logic       det_q,    io_q;     // Previous synced pin levels
  logic       txe_q,    txf_q;    // Previous tx status levels
  logic       fault_q;            // Previous fault level
  logic [1:0] pins_s;             // Synchronised pins
  logic [7:0] set_v;              // Flag set terms
  logic [7:0] clr_v;              // Flag clear terms
  logic       sel_int, sel_any;   // Interface selection decode

  // Pins pass two flops before any use
  scif_sync2 #(.W(2)) u_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({i_card_io_pin, i_card_detect_pin}),
    .o_sync     (pins_s)
  );

  // Receive-length counter for synchronous cards
  scif_len_counter #(.W(LEN_W)) u_len (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .len        (len_bus.cnt)
  );

  // Counter loads from a write to the mode register high byte path
  assign len_bus.load    = i_reg_wr && i_reg_addr == CARD_MODE_ADDR + 16'h0001;
  assign len_bus.max_val = i_reg_wdata;
  assign len_bus.step    = i_len_step && mode_q[MODE_SYNC_BIT];

  // Address match helper
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  // Interface selection and event set terms
  always_comb begin
    sel_int = i_if_select[1];
    sel_any = i_if_select != 2'b00;
    set_v   = '0;
    // Bit seven: timeout in async, length terminal in sync modes
    if (mode_q[MODE_SYNC_BIT] || mode_q[MODE_CLKSTOP_BIT]) begin
      set_v[WAIT_TIMEOUT_BIT] = len_bus.terminal;
    end else begin
      set_v[WAIT_TIMEOUT_BIT] = sel_int ? i_int_wait_timeout
                              : (sel_any && i_ext_wait_timeout);
    end
    // Card event on any detect change or new fault; no gating by clock
    set_v[CARD_CHANGE_BIT]  = (pins_s[0] ^ det_q) ||
                              (i_card_fault && !fault_q);
    set_v[SUPPLY_TIMER_BIT] = i_supply_timeout;
    // Bypass mode raises on io falling edge
    if (mode_q[MODE_BYPASS_BIT]) begin
      set_v[RX_PENDING_BIT] = io_q && !pins_s[1];
    end else begin
      set_v[RX_PENDING_BIT] = sel_any && !i_rx_fifo_empty;
    end
    set_v[TX_STATE_BIT] = (i_tx_fifo_empty && !txe_q) ||
                          (i_tx_fifo_full && !txf_q);
    // Byte sent, unless a break at byte end in character protocol with break detection on
    set_v[TX_DONE_BIT] = (i_byte_sent &&
                          !(mode_q[MODE_BREAK_BIT] &&
                            !mode_q[MODE_BLOCK_BIT] &&
                            i_break_at_end))
                         || (mode_q[MODE_BLOCK_BIT] && i_check_sent);
    set_v[TX_FAULT_BIT] = i_break_detected || i_tx_underrun;
    set_v[RX_FAULT_BIT] = i_rx_overrun || i_rx_parity_err;
  end

  // Clear terms from reads
  always_comb begin
    clr_v = '0;
    if (i_reg_rd && hit(i_reg_addr, CARD_IRQ_FLAGS_ADDR)) begin
      clr_v = clr_v | READ_CLEAR_MASK;
    end
    if (i_tx_ctl_rd) begin
      clr_v = clr_v | TX_CLEAR_MASK;
    end
    if (i_rx_ctl_rd) begin
      clr_v = clr_v | RX_CLEAR_MASK;
    end
  end

  // Next flags, enables, mode, read data and interrupt
  always_comb begin
    // Set wins over clear; disabled sources still set
    flags_d = (flags_q & ~clr_v) | set_v;
    // Receive data flag follows fifo outside bypass
    if (!mode_q[MODE_BYPASS_BIT]) begin
      flags_d[RX_PENDING_BIT] = set_v[RX_PENDING_BIT];
    end
    enable_d = enable_q;
    mode_d   = mode_q;
    if (i_reg_wr && hit(i_reg_addr, CARD_IRQ_ENABLE_ADDR)) begin
      enable_d = i_reg_wdata;
    end
    if (i_reg_wr && hit(i_reg_addr, CARD_MODE_ADDR)) begin
      mode_d = i_reg_wdata;
    end
    // Read data for the addressed register
    rdata_d = '0;
    if (i_reg_rd) begin
      if (hit(i_reg_addr, CARD_IRQ_FLAGS_ADDR)) begin
        rdata_d = flags_q;
      end else if (hit(i_reg_addr, CARD_IRQ_ENABLE_ADDR)) begin
        rdata_d = enable_q;
      end else if (hit(i_reg_addr, CARD_MODE_ADDR)) begin
        rdata_d = mode_q;
      end
    end
    // Bit seven gate serves length terminal in sync modes too
    irq_d = |(flags_d & enable_d);
  end

  // Register stage
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      enable_q <= CARD_IRQ_ENABLE_RST;
      flags_q  <= CARD_IRQ_FLAGS_RST;
      mode_q   <= CARD_MODE_RST;
      rdata_q  <= '0;
      irq_q    <= 1'b0;
      det_q    <= 1'b0;
      io_q     <= 1'b0;
      txe_q    <= 1'b0;
      txf_q    <= 1'b0;
      fault_q  <= 1'b0;
    end else begin
      enable_q <= enable_d;
      flags_q  <= flags_d;
      mode_q   <= mode_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      det_q    <= pins_s[0];
      io_q     <= pins_s[1];
      txe_q    <= i_tx_fifo_empty;
      txf_q    <= i_tx_fifo_full;
      fault_q  <= i_card_fault;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_card_irq  = irq_q;
endmodule : scif_top
`default_nettype wire

/* testbench/scif_checker.sv */
// Concurrent checks on the ports of the card interrupt flag block
`default_nettype none
module scif_checker
  import scif_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_tx_ctl_rd,
  input wire logic        i_rx_ctl_rd,
  input wire logic        i_supply_timeout,
  input wire logic        i_tx_underrun,
  input wire logic        i_rx_overrun,
  input wire logic        i_rx_parity_err,
  input wire logic        o_card_irq
);
  logic [7:0] en_q, en_d; // Mirror of the enable register
  // Next mirror value on an enable write
  always_comb begin
    en_d = en_q;
    if (i_reg_wr && i_reg_addr == CARD_IRQ_ENABLE_ADDR) en_d = i_reg_wdata;
  end
  // Register the mirror
  always_ff @(posedge i_core_clk) begin
    en_q <= i_sys_rst ? CARD_IRQ_ENABLE_RST : en_d;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_en_rd;
    i_reg_rd && i_reg_addr == CARD_IRQ_ENABLE_ADDR |=> o_reg_rdata == $past(en_q);
  endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  property p_en_block;
    en_q == 8'h00 && $past(en_q) == 8'h00 |-> !o_card_irq;
  endproperty
  a_en_block: assert property (p_en_block) else $error("irq while masked");
  property p_supply;
    i_supply_timeout && en_q[5] |=> o_card_irq;
  endproperty
  a_supply: assert property (p_supply) else $error("supply irq missing");
  property p_overrun;
    i_rx_overrun && en_q[0] |=> o_card_irq;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun irq missing");
  property p_underrun;
    i_tx_underrun && en_q[1] |=> o_card_irq;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun irq missing");
  property p_flag_clr;
    i_reg_rd && i_reg_addr == CARD_IRQ_FLAGS_ADDR && en_q == 8'h20
      && !i_supply_timeout |=> !o_card_irq;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("read kept flag");
  property p_tx_clr;
    i_tx_ctl_rd && en_q == 8'h02 && !i_tx_underrun |=> ##[0:1] !o_card_irq;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx read kept flag");
  property p_rx_clr;
    i_rx_ctl_rd && en_q == 8'h01 && !i_rx_overrun && !i_rx_parity_err
      |=> !o_card_irq;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx read kept flag");
  c_irq: cover property (o_card_irq);
  c_flag_rd: cover property (i_reg_rd && i_reg_addr == CARD_IRQ_FLAGS_ADDR);
  c_tx_rd: cover property (i_tx_ctl_rd && en_q == 8'h02);
endmodule : scif_checker
bind scif_top scif_checker i_scif_checker (.*);
`default_nettype wire

/* testbench/scif_core_model.sv */
// Core-side model: counts rising edges of the card interrupt line
`default_nettype none
module scif_core_model (
  input  wire logic i_core_clk, // Processor clock
  input  wire logic i_sys_rst,  // Synchronous reset
  input  wire logic i_irq,      // Card interrupt line
  output var  int   o_rises     // Interrupts taken so far
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_q; // Last sampled line level
  // Take one interrupt per low-to-high change of the line
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rises <= 0;
    end else if (i_irq && !irq_q) begin
      o_rises <= o_rises + 1;
    end
    irq_q <= i_irq;
  end
endmodule : scif_core_model
`default_nettype wire

/* testbench/smart_card_irq_flags_bench.sv */
// Self-checking bench for the card interrupt flag block
`default_nettype none
module smart_card_irq_flags_bench
  import scif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, txrd = 0, rxrd = 0;
  logic rxe = 1, brk = 0, lstep = 0, io = 1, det = 0, irq;
  logic [15:0] addr = '0;
  logic [7:0]  wd = '0, rdata, ev = '0, v;
  logic [1:0]  sel = 2'b10;
  int fails = 0, num_checks = 0, rises, k;
  scif_top i_scif_top (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
    .i_reg_wdata(wd), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
    .i_tx_ctl_rd(txrd), .i_rx_ctl_rd(rxrd), .i_if_select(sel),
    .i_int_wait_timeout(ev[7]), .i_ext_wait_timeout(1'b0),
    .i_supply_timeout(ev[5]), .i_rx_fifo_empty(rxe), .i_tx_fifo_empty(1'b0),
    .i_tx_fifo_full(ev[3]), .i_byte_sent(ev[2]), .i_check_sent(1'b0),
    .i_break_at_end(brk), .i_break_detected(1'b0), .i_tx_underrun(ev[1]),
    .i_rx_overrun(ev[0]), .i_rx_parity_err(1'b0), .i_len_step(lstep),
    .i_card_fault(ev[6]), .i_card_detect_pin(det), .i_card_io_pin(io),
    .o_card_irq(irq));
  scif_core_model i_scif_core_model (.i_core_clk(clk), .i_sys_rst(rst),
    .i_irq(irq), .o_rises(rises));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wd <= d; wr_s <= 1;
    @(posedge clk); wr_s <= 0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd_s <= 1;
    @(posedge clk); rd_s <= 0;
    #1 chk(rdata, e);
  endtask : rdchk
  // One-cycle pulse on event source n
  task automatic fire(input int n);
    @(posedge clk); ev[n] <= 1;
    @(posedge clk); ev <= '0;
  endtask : fire
  // Tx and rx control reads together
  task automatic ctl_rd();
    @(posedge clk); txrd <= 1; rxrd <= 1;
    @(posedge clk); txrd <= 0; rxrd <= 0;
  endtask : ctl_rd
  task automatic t_regs();
    rdchk(CARD_IRQ_ENABLE_ADDR, CARD_IRQ_ENABLE_RST);
    wr(CARD_IRQ_ENABLE_ADDR, 8'ha5);
    rdchk(CARD_IRQ_ENABLE_ADDR, 8'ha5);
    rdchk(16'hfe10, 8'h00);
    wr(CARD_IRQ_FLAGS_ADDR, 8'hff);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h00);
    wr(CARD_IRQ_ENABLE_ADDR, 8'h00);
  endtask : t_regs
  // Every source but bit 4 sets its bit; a flag read leaves bits 0, 1 and 3, the control reads then clear them
  task automatic t_sources();
    foreach (ev[n]) if (n != 4) begin
      fire(n);
      rdchk(CARD_IRQ_FLAGS_ADDR, 8'h01 << n);
      rdchk(CARD_IRQ_FLAGS_ADDR, (8'h01 << n) & ~READ_CLEAR_MASK);
      ctl_rd();
      rdchk(CARD_IRQ_FLAGS_ADDR, 8'h00);
    end
    // Card insertion on the detect pin, seen after the two sync flops
    det <= 1;
    repeat (4) @(posedge clk);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h40);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h00);
    sel <= 2'b01;
    fire(7);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h00);
    sel <= 2'b10;
  endtask : t_sources
  // Masked flag sets silently, enabled flag raises the line
  task automatic t_irq();
    fire(5);
    #1 chk(irq, 1'b0);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h20);
    foreach (v[n]) if (n == 0 || n == 1 || n == 5) begin
      wr(CARD_IRQ_ENABLE_ADDR, 8'h01 << n);
      fire(n);
      #1 chk(irq, 1'b1);
      rdchk(CARD_IRQ_FLAGS_ADDR, 8'h01 << n);
      ctl_rd();
      #1 chk(irq, 1'b0);
    end
    chk(8'(rises), 8'd3);
    wr(CARD_IRQ_ENABLE_ADDR, 8'h00);
  endtask : t_irq
  task automatic t_modes();
    rxe <= 0;
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h10);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h10);
    rxe <= 1;
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h00);
    wr(CARD_MODE_ADDR, 8'h08);
    brk <= 1;
    fire(2);
    brk <= 0;
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h00);
    // Io falling edge sets the rx flag while in bypass
    wr(CARD_MODE_ADDR, 8'h04);
    io <= 0;
    repeat (5) @(posedge clk);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h10);
    io <= 1;
    wr(CARD_MODE_ADDR, 8'h01);
    wr(16'hfe0f, 8'h03);
    for (k = 0; k < 3; k++) begin
      @(posedge clk); lstep <= 1;
      @(posedge clk); lstep <= 0;
    end
    repeat (2) @(posedge clk);
    rdchk(CARD_IRQ_FLAGS_ADDR, 8'h80);
  endtask : t_modes
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_regs();
    t_sources();
    t_irq();
    t_modes();
    tally_and_finish();
  end
  // Cut a hang short
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule : smart_card_irq_flags_bench
`default_nettype wire
